// >>> core/spi_control_one_decode.sv
// first serial control register, pin function decode and interrupts
// Contract
// - bit 7 gates rx-full/fault interrupt, no queue
// - bit 7 gates rx-full/fault interrupt, queue mode
// - bit 6 enables interface, takes the pins
// - enable clear forces idle, clears status flags
// - bit 5 gates tx-empty interrupt, no queue
// - bit 5 gates tx-empty interrupt, queue mode
// - bit 4 picks slave or clock-driving master
// - bit 3 inverts clock, sets idle level
// - both ends must share clock polarity
// - bit 2 picks mid-bit or start-bit first edge
// - slave mode: select pin always select input
// - master, fault off: select pin is gpio
// - master, fault on: fault input or auto output
// - bit 0 picks msb-first or lsb-first shifting
// - bit order never changes data register layout
// - control register one readable and writable
// - select input is active low
// - enable low returns all four pins to gpio
//
// register map, byte offsets, 8-bit values in bits 7:0
//   0x00 control one: irq enables, enable, role, clock, order
//   0x04 control two: bit 7 queue select, bit 4 fault enable
//   0x08 event status, sticky, cleared by reading it
//   0x0C event mask, same layout as the status
//   0x10 live flags, {tx empty, fault, rx full}
//
// event status bits
//   bit 0 rx full request rose
//   bit 1 mode fault request rose
//   bit 2 tx empty request rose
//   bit 3 link clock edge seen as enabled slave
//
// bus timing
//   request taken on the edge with cyc and stb up, ack low
//   ack and read data stand for exactly one cycle after that
//   unmapped offsets answer with zero and drop writes
//   writes need sel bit 0; upper lanes are ignored
//
// limitations
//   only enable, pin and gate decode lives here; the
//   shifter, divider and status logic sit outside and
//   reach this block through the flag inputs
//   queue mode shares the same request gates as plain mode
//
// Added by the designer: the register addresses and the Wishbone register port.
`timescale 1ns/1ps
`include "spi_ctl_params.svh"

module spi_control_one_decode
    import spi_ctl_pkg::*;
#(
    parameter int DATA_W = 8
) (
    input  wire logic              i_clk,
    input  wire logic              i_arst_n,
    // classic wishbone slave
    input  wire logic              i_wb_cyc,
    input  wire logic              i_wb_stb,
    input  wire logic              i_wb_we,
    input  wire logic [7:0]        i_wb_adr,
    input  wire logic [3:0]        i_wb_sel,
    input  wire logic [31:0]       i_wb_dat,
    output logic      [31:0]       o_wb_dat,
    output logic                   o_wb_ack,
    // flags raised by the shifter and status logic
    input  wire logic              i_rx_full_flag,
    input  wire logic              i_mode_fault_flag,
    input  wire logic              i_tx_empty_flag,
    // serial pins as seen from the pad ring
    input  wire logic              i_sck_pin,
    input  wire logic              i_ss_n_pin,
    input  wire logic              i_int_sck,
    input  wire logic              i_int_ss_n,
    output logic                   o_sck_o,
    output logic                   o_sck_oe,
    output logic                   o_ss_n_o,
    output logic                   o_ss_n_oe,
    output logic                   o_pins_owned,
    output logic                   o_ss_owned,
    // decoded configuration for the shifter
    output logic                   o_system_enable,
    output logic                   o_force_idle,
    output logic                   o_clear_status,
    output logic                   o_role_select,
    output logic                   o_clock_polarity,
    output logic                   o_clock_phase,
    output logic                   o_low_bit_first,
    output logic                   o_queue_operation_select,
    output logic [1:0]             o_ss_func,
    output logic                   o_slave_selected,
    output logic                   o_fault_sense,
    output logic                   o_shift_clk,
    output logic [DATA_W-1:0]      o_shift_word,
    input  wire logic [DATA_W-1:0] i_data_reg,
    // interrupt requests
    output logic                   o_rx_fault_irq,
    output logic                   o_tx_empty_irq,
    output logic                   o_irq
);

    // ==========================================================
    // reset release
    // ==========================================================
    logic [1:0] rst_sync_ff;
    logic       rst_n;

    // async assert, clocked release
    // the release must not land near an edge for the whole
    // state word, so two flops retime it to this clock;
    // everything below resets from the retimed copy
    always_ff @(posedge i_clk or negedge i_arst_n) begin
        if (!i_arst_n) begin
            rst_sync_ff <= 2'b00;
        end else begin
            rst_sync_ff <= {rst_sync_ff[0], 1'b1};
        end
    end
    assign rst_n = rst_sync_ff[1];

    // ==========================================================
    // helpers
    // ==========================================================
    // select pin function from role, fault enable, output enable
    //   slave                        -> select input
    //   master, fault off            -> general purpose
    //   master, fault on, oe low     -> fault input
    //   master, fault on, oe high    -> automatic select out
    // role wins over the other two bits, so a slave never
    // loses its select input to a stale control two value
    function automatic ss_func_e ss_decode(input logic role,
                                           input logic fault_en,
                                           input logic ss_oe);
        ss_func_e f;
        f = SS_SLAVE_IN;
        if (!role) begin
            f = SS_SLAVE_IN;
        end else if (!fault_en) begin
            f = SS_GPIO;
        end else if (!ss_oe) begin
            f = SS_FAULT_IN;
        end else begin
            f = SS_AUTO_OUT;
        end
        return f;
    endfunction

    // bit reversal for lsb-first shifting
    // only the shifter's view flips; software always sees the
    // word with its top bit high
    function automatic logic [DATA_W-1:0] rev(input logic [DATA_W-1:0] d);
        logic [DATA_W-1:0] r;
        r = '0;
        for (int k = 0; k < DATA_W; k++) begin
            r[k] = d[DATA_W-1-k];
        end
        return r;
    endfunction

    // ==========================================================
    // state
    // ==========================================================
    // all registered state but the reset synchroniser lives in one word; the helpers
    // below are plain wires decoded from it
    state_s st_ff;
    state_s nxt_st;
    logic   acc;
    logic   wr_lo;
    logic   sys_en;
    logic   role;
    logic   clock_polarity;
    logic   rx_req;
    logic   tx_req;
    logic   sck_edge;
    logic   ss_n_s;
    ss_func_e ss_f;

    assign acc      = i_wb_cyc && i_wb_stb && !st_ff.ack;
    assign wr_lo    = acc && i_wb_we && i_wb_sel[0];
    assign sys_en   = st_ff.ctrl_one[`BIT_SYS_EN];
    assign role     = st_ff.ctrl_one[`BIT_ROLE];
    assign clock_polarity     = st_ff.ctrl_one[`BIT_CLOCK_POLARITY];
    assign ss_f     = ss_decode(role, st_ff.ctrl_two[`BIT_FAULT_EN],
                                st_ff.ctrl_one[`BIT_SS_OE]);
    assign sck_edge = st_ff.sck_sync[1] ^ st_ff.sck_prev;
    assign ss_n_s   = st_ff.ss_sync[1];

    // combinational request gates so a late enable fires at once
    assign rx_req = st_ff.ctrl_one[`BIT_RX_IRQ_EN]
                  && (i_rx_full_flag || i_mode_fault_flag);
    assign tx_req = st_ff.ctrl_one[`BIT_TX_IRQ_EN]
                  && i_tx_empty_flag;

    // next state: bus access, sync, sticky events
    // order matters: events are merged after the bus write so
    // a status read in the same cycle as an event keeps the
    // event, and the disable clear comes last so nothing
    // survives while the interface is off
    // ack is refused while high, which keeps it one cycle wide
    // even when the master holds its request a little long
    always_comb begin
        logic [3:0] ev;
        ev = 4'h0;
        nxt_st = st_ff;
        // pin inputs pass two flops before anything reads them
        nxt_st.sck_sync = {st_ff.sck_sync[0], i_sck_pin};
        nxt_st.ss_sync  = {st_ff.ss_sync[0], i_ss_n_pin};
        nxt_st.sck_prev = st_ff.sck_sync[1];
        nxt_st.irq_rx_prev = rx_req;
        nxt_st.irq_tx_prev = tx_req;
        nxt_st.ack = acc;
        nxt_st.flags = {i_tx_empty_flag, i_mode_fault_flag, i_rx_full_flag};
        // rising request edges and clock edges are the events
        ev[`EVT_RX_FULL]  = rx_req && !st_ff.irq_rx_prev && i_rx_full_flag;
        ev[`EVT_FAULT]    = rx_req && !st_ff.irq_rx_prev && i_mode_fault_flag;
        ev[`EVT_TX_EMPTY] = tx_req && !st_ff.irq_tx_prev;
        ev[`EVT_CLK_EDGE] = sys_en && !role && sck_edge;
        if (wr_lo) begin
            unique case (i_wb_adr)
                `ADR_CTRL_ONE: nxt_st.ctrl_one = i_wb_dat[7:0];
                `ADR_CTRL_TWO: nxt_st.ctrl_two = i_wb_dat[7:0]
                                               & 8'hB3;
                `ADR_IRQ_MASK: nxt_st.irq_mask = i_wb_dat[3:0];
                default: ;
            endcase
        end
        nxt_st.rd_data = 8'h00;
        if (acc && !i_wb_we) begin
            unique case (i_wb_adr)
                `ADR_CTRL_ONE: nxt_st.rd_data = st_ff.ctrl_one;
                `ADR_CTRL_TWO: nxt_st.rd_data = st_ff.ctrl_two;
                `ADR_IRQ_STAT: nxt_st.rd_data = {4'h0, st_ff.irq_stat};
                `ADR_IRQ_MASK: nxt_st.rd_data = {4'h0, st_ff.irq_mask};
                `ADR_FLAGS:    nxt_st.rd_data = {5'h00, st_ff.flags};
                default:       nxt_st.rd_data = 8'h00;
            endcase
        end
        // read clears, but a same-cycle event still lands
        if (acc && !i_wb_we && i_wb_adr == `ADR_IRQ_STAT) begin
            nxt_st.irq_stat = ev;
        end else begin
            nxt_st.irq_stat = st_ff.irq_stat | ev;
        end
        // disabled interface keeps no pending status
        if (!sys_en) begin
            nxt_st.irq_stat = 4'h0;
        end
    end

    // single registered copy of the whole state word
    // select synchroniser starts high: no false select at reset
    always_ff @(posedge i_clk or negedge rst_n) begin
        if (!rst_n) begin
            st_ff <= '{
                ctrl_one:    `CTRL_ONE_RST,
                ctrl_two:    `CTRL_TWO_RST,
                irq_stat:    4'h0,
                irq_mask:    4'h0,
                flags:       3'h0,
                rd_data:     8'h00,
                ack:         1'b0,
                sck_sync:    2'b00,
                sck_prev:    1'b0,
                ss_sync:     2'b11,
                irq_rx_prev: 1'b0,
                irq_tx_prev: 1'b0
            };
        end else begin
            st_ff <= nxt_st;
        end
    end

    // ==========================================================
    // bus answers
    // ==========================================================
    // both come straight from flops, so the master sees settled
    // values for the whole ack cycle; upper lanes read as zero
    assign o_wb_ack = st_ff.ack;
    assign o_wb_dat = {24'h000000, st_ff.rd_data};

    // ==========================================================
    // configuration decode
    // ==========================================================
    // register bits go out as they are; the shifter and divider
    // must only sample them while idle, since software may
    // rewrite control one in the middle of a frame
    assign o_system_enable  = sys_en;
    assign o_force_idle     = !sys_en;
    assign o_clear_status   = !sys_en;
    assign o_role_select    = role;
    assign o_clock_polarity = clock_polarity;
    assign o_clock_phase    = st_ff.ctrl_one[`BIT_CLOCK_PHASE];
    assign o_low_bit_first  = st_ff.ctrl_one[`BIT_LSB_FIRST];
    assign o_queue_operation_select = st_ff.ctrl_two[`BIT_QUEUE_SEL];
    assign o_ss_func        = ss_f;
    // data register itself stays msb-high; only the shift view flips
    assign o_shift_word = st_ff.ctrl_one[`BIT_LSB_FIRST]
                        ? rev(i_data_reg) : i_data_reg;

    // ==========================================================
    // pin ownership
    // ==========================================================
    // the pad ring uses the owned flags to pick between this
    // block and the port logic; output enables are gated by the
    // system enable as well, so a disabled block never drives
    // a pin, and all pins go back to gpio while disabled
    assign o_pins_owned = sys_en;
    assign o_ss_owned   = sys_en && (ss_f != SS_GPIO);
    // master drives the clock, polarity as an inverter in series
    assign o_sck_oe = sys_en && role;
    assign o_sck_o  = i_int_sck ^ clock_polarity;
    // slave view of the link clock, polarity removed
    assign o_shift_clk = st_ff.sck_sync[1] ^ clock_polarity;
    assign o_ss_n_oe = sys_en && (ss_f == SS_AUTO_OUT);
    assign o_ss_n_o  = i_int_ss_n;
    // select is low-true; fault sense reuses the same pin
    assign o_slave_selected = sys_en && (ss_f == SS_SLAVE_IN)
                            && !ss_n_s;
    assign o_fault_sense    = sys_en && (ss_f == SS_FAULT_IN)
                            && !ss_n_s;

    // ==========================================================
    // interrupts
    // ==========================================================
    // direct requests are level gates and follow the flags at
    // once; the summary line instead follows the sticky status
    // and mask, so a short flag pulse that raises an enabled, idle request while the interface is enabled is never lost
    assign o_rx_fault_irq = rx_req;
    assign o_tx_empty_irq = tx_req;
    assign o_irq = |(st_ff.irq_stat & st_ff.irq_mask);

endmodule

// >>> core/spi_ctl_params.svh
// offsets, field positions and reset values for the control block
`ifndef SPI_CTL_PARAMS_SVH
`define SPI_CTL_PARAMS_SVH
`define ADR_CTRL_ONE    8'h00
`define ADR_CTRL_TWO    8'h04
`define ADR_IRQ_STAT    8'h08
`define ADR_IRQ_MASK    8'h0C
`define ADR_FLAGS       8'h10
`define BIT_RX_IRQ_EN   7
`define BIT_SYS_EN      6
`define BIT_TX_IRQ_EN   5
`define BIT_ROLE        4
`define BIT_CLOCK_POLARITY        3
`define BIT_CLOCK_PHASE        2
`define BIT_SS_OE       1
`define BIT_LSB_FIRST   0
`define BIT_FAULT_EN    4
`define BIT_QUEUE_SEL   7
`define CTRL_ONE_RST    8'h04
`define CTRL_TWO_RST    8'h00
`define EVT_RX_FULL     0
`define EVT_FAULT       1
`define EVT_TX_EMPTY    2
`define EVT_CLK_EDGE    3
`endif

// >>> core/spi_ctl_pkg.sv
// types shared by the serial control block
package spi_ctl_pkg;
    typedef enum logic [1:0] {
        SS_GPIO,
        SS_SLAVE_IN,
        SS_FAULT_IN,
        SS_AUTO_OUT
    } ss_func_e;
    typedef struct packed {
        logic [7:0] ctrl_one;
        logic [7:0] ctrl_two;
        logic [3:0] irq_stat;
        logic [3:0] irq_mask;
        logic [2:0] flags;
        logic [7:0] rd_data;
        logic       ack;
        logic [1:0] sck_sync;
        logic       sck_prev;
        logic [1:0] ss_sync;
        logic       irq_rx_prev;
        logic       irq_tx_prev;
    } state_s;
endpackage

// >>> tb/spi_ctl_chk.sv
// port checker for the control decode block
`timescale 1ns/1ps
module spi_ctl_chk
    import spi_ctl_pkg::*;
(
    input wire logic       i_clk,
    input wire logic       i_arst_n,
    input wire logic       i_wb_cyc,
    input wire logic       i_wb_stb,
    input wire logic       i_rx_full_flag,
    input wire logic       i_mode_fault_flag,
    input wire logic       i_tx_empty_flag,
    input wire logic       i_int_sck,
    input wire logic       o_wb_ack,
    input wire logic       o_sck_o,
    input wire logic       o_sck_oe,
    input wire logic       o_ss_n_oe,
    input wire logic       o_pins_owned,
    input wire logic       o_system_enable,
    input wire logic       o_force_idle,
    input wire logic       o_role_select,
    input wire logic       o_clock_polarity,
    input wire logic [1:0] o_ss_func,
    input wire logic       o_rx_fault_irq,
    input wire logic       o_tx_empty_irq
);
    default clocking @(posedge i_clk); endclocking
    default disable iff (!i_arst_n);
    // ========================================
    // bus answer, enable and pins
    a_ack_one_pulse: assert property (
        i_wb_cyc && i_wb_stb && !o_wb_ack |=> o_wb_ack ##1 !o_wb_ack)
        else $error("bus ack not a single pulse");
    a_idle_forced: assert property (
        !o_system_enable |-> o_force_idle) else $error("idle not forced");
    a_pins_released: assert property (
        !o_system_enable |-> !(o_pins_owned || o_sck_oe || o_ss_n_oe))
        else $error("pins held while disabled");
    a_master_drives: assert property (
        o_sck_oe == (o_system_enable && o_role_select))
        else $error("clock driver wrong for role");
    a_clk_inverter: assert property (
        o_sck_o == (i_int_sck ^ o_clock_polarity))
        else $error("clock polarity wrong");
    a_slave_input: assert property (
        o_system_enable && !o_role_select |-> o_ss_func == SS_SLAVE_IN)
        else $error("slave select function wrong");
    a_auto_output: assert property (
        o_ss_n_oe |-> o_role_select && o_ss_func == SS_AUTO_OUT)
        else $error("select driven outside auto output");
    // ========================================
    // interrupt gating, flags must be behind each request
    a_rx_gate: assert property (
        o_rx_fault_irq |-> i_rx_full_flag || i_mode_fault_flag)
        else $error("rx irq without flag");
    a_tx_gate: assert property (
        o_tx_empty_irq |-> i_tx_empty_flag) else $error("tx irq without flag");
    c_both_irq: cover property (o_rx_fault_irq && o_tx_empty_irq);
    c_auto_out: cover property (o_ss_n_oe);
    c_master: cover property (o_sck_oe);
endmodule
bind spi_control_one_decode spi_ctl_chk chk (.i_clk, .i_arst_n,
    .i_wb_cyc, .i_wb_stb, .i_rx_full_flag, .i_mode_fault_flag,
    .i_tx_empty_flag, .i_int_sck, .o_wb_ack, .o_sck_o, .o_sck_oe,
    .o_ss_n_oe, .o_pins_owned, .o_system_enable, .o_force_idle,
    .o_role_select, .o_clock_polarity, .o_ss_func, .o_rx_fault_irq,
    .o_tx_empty_irq);

// >>> tb/spi_link_peer.sv
// external link master: one frame of clock under an active-low select
`timescale 1ns/1ps
module spi_link_peer (
    input  wire logic i_go,
    input  wire logic i_pol,
    output logic      o_sck,
    output logic      o_ss_n
);
    // select idles high, as a pulled-up line would
    initial begin
        o_sck = 1'b0;
        o_ss_n = 1'b1;
    end
    // idle level follows the shared polarity setting
    always @(i_pol) if (o_ss_n) o_sck = i_pol;
    // eight bits at 800 ns, clock still outside the frame
    always @(posedge i_go) begin
        o_ss_n = 1'b0;
        repeat (16) #400 o_sck = ~o_sck;
        #400 o_ss_n = 1'b1;
    end
endmodule

// >>> tb/spi_control_one_decode_bench.sv
// bench for the control register decode block
`timescale 1ns/1ps
module spi_control_one_decode_bench;
    import spi_ctl_pkg::*;
    logic i_clk, i_arst_n, i_wb_cyc, i_wb_stb, i_wb_we, i_rx_full_flag;
    logic i_mode_fault_flag, i_tx_empty_flag, i_int_sck, i_int_ss_n, go;
    logic i_sck_pin, i_ss_n_pin, o_wb_ack, o_sck_o, o_sck_oe, o_ss_n_o;
    logic o_ss_n_oe, o_pins_owned, o_ss_owned, o_system_enable, o_irq;
    logic o_force_idle, o_clear_status, o_role_select, o_clock_polarity;
    logic o_clock_phase, o_low_bit_first, o_queue_operation_select;
    logic o_slave_selected, o_rx_fault_irq, o_tx_empty_irq;
    logic [7:0]  i_wb_adr, i_data_reg, o_shift_word, q, v, c;
    logic [3:0]  i_wb_sel;
    logic [31:0] i_wb_dat, o_wb_dat;
    logic [1:0]  o_ss_func;
    int          n_mismatch, check_count, cycles, seed, i, f;
    spi_control_one_decode dut (.i_clk, .i_arst_n, .i_wb_cyc, .i_wb_stb,
        .i_wb_we, .i_wb_adr, .i_wb_sel, .i_wb_dat, .o_wb_dat, .o_wb_ack,
        .i_rx_full_flag, .i_mode_fault_flag, .i_tx_empty_flag, .i_sck_pin,
        .i_ss_n_pin, .i_int_sck, .i_int_ss_n, .o_sck_o, .o_sck_oe,
        .o_ss_n_o, .o_ss_n_oe, .o_pins_owned, .o_ss_owned, .o_system_enable,
        .o_force_idle, .o_clear_status, .o_role_select, .o_clock_polarity,
        .o_clock_phase, .o_low_bit_first, .o_queue_operation_select,
        .o_ss_func, .o_slave_selected, .o_fault_sense(), .o_shift_clk(),
        .o_shift_word, .i_data_reg, .o_rx_fault_irq, .o_tx_empty_irq, .o_irq);
    spi_link_peer peer (.i_go(go), .i_pol(o_clock_polarity),
        .o_sck(i_sck_pin), .o_ss_n(i_ss_n_pin));
    // ========================================
    // helpers
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        check_count++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    task automatic complete_run;
        $display("checks %0d mismatches %0d", check_count, n_mismatch);
        if (n_mismatch == 0 && check_count > 0) $display("All tests passed");
        else $display("Some tests failed");
        $finish;
    endtask
    // one classic cycle; request held until ack is sampled at an edge
    task automatic wb(input logic w, input logic [7:0] a,
                      input logic [7:0] d, output logic [7:0] r);
        @(posedge i_clk);
        {i_wb_cyc, i_wb_stb, i_wb_we, i_wb_adr} <= {2'b11, w, a};
        i_wb_dat <= {24'h0, d};
        do @(posedge i_clk); while (o_wb_ack !== 1'b1);
        r = o_wb_dat[7:0];
        {i_wb_cyc, i_wb_stb} <= 2'b00;
    endtask
    function automatic logic [7:0] rev(input logic [7:0] d);
        for (int k = 0; k < 8; k++) rev[k] = d[7 - k];
    endfunction
    initial begin
        i_clk = 1'b0;
        forever #50 i_clk = ~i_clk;
    end
    // hang guard, far above the few hundred cycles needed
    always @(posedge i_clk) begin
        cycles++;
        if (cycles == 20000) begin
            n_mismatch++;
            complete_run();
        end
    end
    // ========================================
    // main sequence
    initial begin
        {i_arst_n, i_wb_cyc, i_wb_stb, i_wb_we, i_int_sck, go} = '0;
        {i_rx_full_flag, i_mode_fault_flag, i_tx_empty_flag} = '0;
        {i_wb_adr, i_data_reg, i_wb_dat, i_int_ss_n} = '0;
        i_wb_sel = 4'hF;
        seed = 20;
        repeat (16) @(posedge i_clk);
        i_arst_n <= 1'b1;
        repeat (3) @(posedge i_clk);
        wb(0, 8'h00, 8'h00, q); chk(q, 8'h04);
        wb(1, 8'h14, 8'hFF, q); wb(0, 8'h14, 8'h00, q); chk(q, 8'h00);
        // random settings, read back and decoded
        for (i = 0; i < 6; i++) begin
            v = 8'($random(seed));
            i_data_reg <= 8'($random(seed));
            i_int_sck <= v[7];
            wb(1, 8'h00, v, q); wb(0, 8'h00, 8'h00, q);
            chk(q, v);
            chk({o_system_enable, o_role_select, o_clock_polarity,
                 o_clock_phase, o_low_bit_first, o_force_idle, o_clear_status,
                 o_pins_owned}, {v[6], v[4], v[3], v[2], v[0], ~v[6], ~v[6],
                 v[6]});
            chk({o_sck_o, o_sck_oe}, {v[7] ^ v[3], v[6] & v[4]});
            chk(o_shift_word, v[0] ? rev(i_data_reg) : i_data_reg);
        end
        // select pin function over role, output enable, fault enable
        for (i = 0; i < 8; i++) begin
            wb(1, 8'h04, {3'h0, i[2], 4'h0}, q);
            wb(1, 8'h00, {3'h2, i[0], 2'h0, i[1], 1'b0}, q);
            f = !i[0] ? 1 : !i[2] ? 0 : i[1] ? 3 : 2;
            @(negedge i_clk);
            chk({o_ss_func, o_ss_n_oe, o_ss_owned},
                {f[1:0], f == 3, f != 0});
        end
        // request gating, both queue settings, all flag mixes
        for (i = 0; i < 32; i++) begin
            c = i[3] ? 8'hE0 : 8'h40;
            if (i[2:0] == 0) begin
                wb(1, 8'h04, {i[4], 7'h0}, q);
                wb(1, 8'h00, c, q);
            end
            @(posedge i_clk);
            {i_tx_empty_flag, i_mode_fault_flag, i_rx_full_flag} <= i[2:0];
            @(negedge i_clk);
            chk({o_rx_fault_irq, o_tx_empty_irq, o_queue_operation_select},
                {c[7] & (i[0] | i[1]), c[5] & i[2], i[4]});
        end
        // sticky status, mask and clear on read
        @(posedge i_clk);
        {i_tx_empty_flag, i_mode_fault_flag, i_rx_full_flag} <= 3'h0;
        wb(1, 8'h0C, 8'h01, q); wb(0, 8'h08, 8'h00, q);
        chk(o_irq, 1'b0);
        @(posedge i_clk) i_rx_full_flag <= 1'b1;
        repeat (4) @(negedge i_clk);
        chk(o_irq, 1'b1);
        @(posedge i_clk) {i_rx_full_flag, i_tx_empty_flag} <= 2'b01;
        wb(0, 8'h08, 8'h00, q); chk(q, 8'h05);
        repeat (2) @(negedge i_clk);
        chk(o_irq, 1'b0);
        // one frame from the external master into an enabled slave
        @(posedge i_clk) i_tx_empty_flag <= 1'b0;
        wb(1, 8'h00, 8'h40, q); wb(0, 8'h08, 8'h00, q);
        @(posedge i_clk) go <= 1'b1;
        repeat (10) @(negedge i_clk);
        chk({o_slave_selected, o_ss_owned}, 2'b11);
        repeat (80) @(posedge i_clk);
        go <= 1'b0;
        chk(o_slave_selected, 1'b0);
        wb(0, 8'h08, 8'h00, q); chk(q, 8'h08);
        complete_run();
    end
endmodule
